// >>> design/uart_map_pkg.sv
// Register locations, field layouts and reset values of one channel register map
package uart_map_pkg;

  // ----------------------------------------
  // Locations selected by the three address lines
  // ----------------------------------------
  localparam logic [2:0] LOC_DATA        = 3'h0;
  localparam logic [2:0] LOC_ENABLE      = 3'h1;
  localparam logic [2:0] LOC_STATUS      = 3'h2;
  localparam logic [2:0] LOC_LINE_CTRL   = 3'h3;
  localparam logic [2:0] LOC_MODEM_CTRL  = 3'h4;
  localparam logic [2:0] LOC_LINE_STAT   = 3'h5;
  localparam logic [2:0] LOC_MODEM_STAT  = 3'h6;
  localparam logic [2:0] LOC_SCRATCH     = 3'h7;
  localparam logic [2:0] LOC_FLOW_BASE   = 3'h4;

  // ----------------------------------------
  // Bank selection
  // ----------------------------------------
  localparam logic [7:0] ENH_BANK_KEY    = 8'hBF;
  localparam logic [7:0] DIV_ZERO        = 8'h00;
  localparam int         DIV_ACCESS_BIT  = 7;
  localparam int         SWAP_BIT        = 6;
  localparam int         FILL_SEL_BIT    = 7;
  localparam int         ENH_ENABLE_BIT  = 4;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int FIFO_ENABLE_BIT   = 0;
  localparam int RX_FIFO_RESET_BIT = 1;
  localparam int TX_FIFO_RESET_BIT = 2;
  localparam int DMA_MODE_BIT      = 3;
  localparam int TX_TRIG_LSB       = 4;
  localparam int RX_TRIG_LSB       = 6;
  localparam int DTR_BIT           = 0;
  localparam int RTS_BIT           = 1;
  localparam int INT_OUT_EN_BIT    = 3;
  localparam int LOOPBACK_BIT      = 4;

  // ----------------------------------------
  // Masks of enhanced, reserved and implemented bits
  // ----------------------------------------
  localparam logic [7:0] IER_ENH_MASK    = 8'hF0;
  localparam logic [5:0] ISR_ENH_MASK    = 6'h30;
  localparam logic [7:0] FCR_ENH_MASK    = 8'h30;
  localparam logic [7:0] MCR_ENH_MASK    = 8'hE0;
  localparam logic [7:0] MCR_RSVD_MASK   = 8'h04;
  localparam logic [7:0] EMS_RSVD_MASK   = 8'h0C;
  localparam logic [7:0] FEATURE_CONTROL_RSVD_MASK  = 8'h08;
  localparam logic [7:0] DLD_MASK        = 8'h0F;
  localparam logic [1:0] FIFOS_ON_FLAGS  = 2'h3;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0]  RESET_BYTE     = 8'h00;
  localparam logic [13:0] PIN_IDLE       = 14'h3FFF;

endpackage

// >>> design/bus_pin_sync.sv
// Two flip-flop synchroniser for the host bus pins
module bus_pin_sync #(
  parameter int                 WIDTH = 14,
  parameter logic [WIDTH-1:0]   INIT  = '1
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // Pins and synchronised copy
  input  wire logic [WIDTH-1:0] pins_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;

  // Each bit passes two flops; only the second reads the first
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
        meta_ff[i]  <= INIT[i];
        sync_out[i] <= INIT[i];
      end else begin
        meta_ff[i]  <= pins_in[i];
        sync_out[i] <= meta_ff[i];
      end
    end
  end

endmodule

// >>> design/uart_register_map_decoder.sv
// Register select and field layout logic for one channel of a two-channel UART
module uart_register_map_decoder #(
  parameter logic [7:0] REVISION_CODE       = 8'h5A,  // Arbitrary value
  parameter logic [7:0] IDENTIFICATION_CODE = 8'h3C   // Arbitrary value
) (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Host bus pins
  input  wire logic       cs_n_in,
  input  wire logic       rd_n_in,
  input  wire logic       wr_n_in,
  input  wire logic [2:0] addr_in,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe_out,
  // Channel state read by the host
  input  wire logic [7:0] rx_holding_in,
  input  wire logic [5:0] int_source_in,
  input  wire logic [7:0] line_status_in,
  input  wire logic [7:0] modem_status_in,
  input  wire logic [7:0] rx_fill_level_in,
  input  wire logic [7:0] tx_fill_level_in,
  // Access strobes
  output logic            rx_read_stb_out,
  output logic            int_status_read_stb_out,
  output logic            line_status_read_stb_out,
  output logic            modem_status_read_stb_out,
  output logic            tx_load_stb_out,
  output logic            trigger_load_stb_out,
  output logic            rx_fifo_reset_out,
  output logic            tx_fifo_reset_out,
  output logic [7:0]      tx_holding_out,
  output logic [7:0]      fifo_trigger_level_out,
  // Configuration seen by the channel
  output logic [7:0]      divisor_low_out,
  output logic [7:0]      divisor_high_out,
  output logic [3:0]      divisor_fraction_out,
  output logic [7:0]      interrupt_enable_out,
  output logic            fifo_enable_out,
  output logic            dma_mode_out,
  output logic [1:0]      tx_trigger_out,
  output logic [1:0]      rx_trigger_out,
  output logic [7:0]      line_control_out,
  output logic [7:0]      modem_control_out,
  output logic            dtr_out,
  output logic            rts_out,
  output logic            interrupt_output_enable_out,
  output logic            loopback_out,
  output logic [7:0]      feature_control_out,
  output logic [7:0]      enhanced_function_out,
  output logic [7:0]      enhanced_mode_select_out,
  output logic [7:0]      flow_resume_char_one_out,
  output logic [7:0]      flow_resume_char_two_out,
  output logic [7:0]      flow_stop_char_one_out,
  output logic [7:0]      flow_stop_char_two_out
);

  // ----------------------------------------
  // Bus synchronisation
  // ----------------------------------------
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_READ = 2'b10
  } bus_state_t;

  bus_state_t  bus_state_ff;
  logic [13:0] pins_sync;
  logic        cs_s;
  logic        rd_s;
  logic        wr_s;
  logic [2:0]  addr_s;
  logic [7:0]  wdata_s;
  logic        wr_prev_ff;
  logic        cs_prev_ff;
  logic [2:0]  addr_prev_ff;
  logic [7:0]  data_prev_ff;

  bus_pin_sync #(
    .WIDTH (14),
    .INIT  (uart_map_pkg::PIN_IDLE)
  ) u_sync (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .pins_in  ({cs_n_in, rd_n_in, wr_n_in, addr_in, data_in}),
    .sync_out (pins_sync)
  );

  // Active-high views of the synchronised strobes
  assign cs_s    = ~pins_sync[13];
  assign rd_s    = ~pins_sync[12];
  assign wr_s    = ~pins_sync[11];
  assign addr_s  = pins_sync[10:8];
  assign wdata_s = pins_sync[7:0];

  // ----------------------------------------
  // Stored registers
  // ----------------------------------------
  logic [7:0] dll_ff;
  logic [7:0] dlm_ff;
  logic [3:0] dld_ff;
  logic [7:0] ier_ff;
  logic [7:0] fcr_ff;
  logic [7:0] lcr_ff;
  logic [7:0] mcr_ff;
  logic [7:0] scratch_ff;
  logic [7:0] feature_control_ff;
  logic [7:0] efr_ff;
  logic [7:0] enhanced_mode_select_ff;
  logic [7:0] trg_ff;
  logic [7:0] thr_ff;
  logic [7:0] flow_char_ff [4];

  // ----------------------------------------
  // Bank decode
  // ----------------------------------------
  logic       bank_enh;
  logic       div_acc;
  logic       div_zero;
  logic       enh_on;
  logic [7:0] fill_sel;
  logic [7:0] ier_eff;
  logic [7:0] mcr_eff;
  logic [7:0] isr_eff;
  logic [7:0] nxt_rdata;
  logic       wr_fire;
  logic       rd_fire;

  assign bank_enh = (lcr_ff == uart_map_pkg::ENH_BANK_KEY);
  assign div_acc  = lcr_ff[uart_map_pkg::DIV_ACCESS_BIT] && !bank_enh;
  assign div_zero = (dll_ff == uart_map_pkg::DIV_ZERO) && (dlm_ff == uart_map_pkg::DIV_ZERO);
  assign enh_on   = efr_ff[uart_map_pkg::ENH_ENABLE_BIT];
  assign fill_sel = feature_control_ff[uart_map_pkg::FILL_SEL_BIT] ? tx_fill_level_in : rx_fill_level_in;

  // Enhanced bits vanish while the enhance bit is clear
  assign ier_eff = enh_on ? ier_ff : (ier_ff & ~uart_map_pkg::IER_ENH_MASK);
  assign mcr_eff = enh_on ? mcr_ff : (mcr_ff & ~uart_map_pkg::MCR_ENH_MASK);
  assign isr_eff = {fcr_ff[uart_map_pkg::FIFO_ENABLE_BIT] ? uart_map_pkg::FIFOS_ON_FLAGS : 2'h0,
                    enh_on ? int_source_in : (int_source_in & ~uart_map_pkg::ISR_ENH_MASK)};

  // Access events, honoured only under chip select
  assign rd_fire = (bus_state_ff == BUS_IDLE) && rd_s && cs_s;
  assign wr_fire = !wr_s && wr_prev_ff && cs_prev_ff;

  // ----------------------------------------
  // Read multiplexer
  // ----------------------------------------
  always_comb begin
    nxt_rdata = uart_map_pkg::RESET_BYTE;
    if (addr_s == uart_map_pkg::LOC_DATA) begin
      if (bank_enh) begin
        nxt_rdata = fill_sel;
      end else if (div_acc) begin
        nxt_rdata = div_zero ? REVISION_CODE : dll_ff;
      end else begin
        nxt_rdata = rx_holding_in;
      end
    end else if (addr_s == uart_map_pkg::LOC_ENABLE) begin
      if (bank_enh) begin
        nxt_rdata = feature_control_ff;
      end else if (div_acc) begin
        nxt_rdata = div_zero ? IDENTIFICATION_CODE : dlm_ff;
      end else begin
        nxt_rdata = ier_eff;
      end
    end else if (addr_s == uart_map_pkg::LOC_STATUS) begin
      if (bank_enh) begin
        nxt_rdata = efr_ff;
      end else if (div_acc && enh_on) begin
        nxt_rdata = {4'h0, dld_ff};
      end else begin
        nxt_rdata = isr_eff;
      end
    end else if (addr_s == uart_map_pkg::LOC_LINE_CTRL) begin
      nxt_rdata = lcr_ff;
    end else if (bank_enh) begin
      nxt_rdata = flow_char_ff[addr_s[1:0]];
    end else if (addr_s == uart_map_pkg::LOC_MODEM_CTRL) begin
      nxt_rdata = mcr_eff & ~uart_map_pkg::MCR_RSVD_MASK;
    end else if (addr_s == uart_map_pkg::LOC_LINE_STAT) begin
      nxt_rdata = line_status_in;
    end else if (addr_s == uart_map_pkg::LOC_MODEM_STAT) begin
      nxt_rdata = modem_status_in;
    end else if (feature_control_ff[uart_map_pkg::SWAP_BIT]) begin
      nxt_rdata = fill_sel;
    end else begin
      nxt_rdata = scratch_ff;
    end
  end

  // ----------------------------------------
  // Bus sequencing
  // ----------------------------------------

  // Sample previous pin state to find the end of a write strobe
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_prev_ff   <= 1'b0;
      cs_prev_ff   <= 1'b0;
      addr_prev_ff <= 3'h0;
      data_prev_ff <= uart_map_pkg::RESET_BYTE;
    end else begin
      wr_prev_ff   <= wr_s;
      cs_prev_ff   <= cs_s;
      addr_prev_ff <= addr_s;
      data_prev_ff <= wdata_s;
    end
  end

  // Read data is latched once and driven until the strobe ends
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      bus_state_ff <= BUS_IDLE;
      data_out     <= uart_map_pkg::RESET_BYTE;
      data_oe_out  <= 1'b0;
    end else begin
      case (bus_state_ff)
        BUS_IDLE: begin
          if (rd_fire) begin
            bus_state_ff <= BUS_READ;
            data_out     <= nxt_rdata;
            data_oe_out  <= 1'b1;
          end
        end
        BUS_READ: begin
          if (!rd_s || !cs_s) begin
            bus_state_ff <= BUS_IDLE;
            data_oe_out  <= 1'b0;
          end
        end
        default: begin
          bus_state_ff <= BUS_IDLE;
          data_oe_out  <= 1'b0;
        end
      endcase
    end
  end

  // Read side effects for the channel logic
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_read_stb_out           <= 1'b0;
      int_status_read_stb_out   <= 1'b0;
      line_status_read_stb_out  <= 1'b0;
      modem_status_read_stb_out <= 1'b0;
    end else begin
      rx_read_stb_out           <= rd_fire && !bank_enh && !div_acc && (addr_s == uart_map_pkg::LOC_DATA);
      int_status_read_stb_out   <= rd_fire && !bank_enh && !(div_acc && enh_on) &&
                                   (addr_s == uart_map_pkg::LOC_STATUS);
      line_status_read_stb_out  <= rd_fire && !bank_enh && (addr_s == uart_map_pkg::LOC_LINE_STAT);
      modem_status_read_stb_out <= rd_fire && !bank_enh && (addr_s == uart_map_pkg::LOC_MODEM_STAT);
    end
  end

  // ----------------------------------------
  // Write decode
  // ----------------------------------------

  // Locations 0 to 2 across the three banks
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      dll_ff  <= uart_map_pkg::RESET_BYTE;
      dlm_ff  <= uart_map_pkg::RESET_BYTE;
      dld_ff  <= 4'h0;
      ier_ff  <= uart_map_pkg::RESET_BYTE;
      fcr_ff  <= uart_map_pkg::RESET_BYTE;
      feature_control_ff <= uart_map_pkg::RESET_BYTE;
      efr_ff  <= uart_map_pkg::RESET_BYTE;
      trg_ff  <= uart_map_pkg::RESET_BYTE;
      thr_ff  <= uart_map_pkg::RESET_BYTE;
    end else if (wr_fire) begin
      if (addr_prev_ff == uart_map_pkg::LOC_DATA) begin
        if (bank_enh) begin
          trg_ff <= data_prev_ff;
        end else if (div_acc) begin
          dll_ff <= data_prev_ff;
        end else begin
          thr_ff <= data_prev_ff;
        end
      end else if (addr_prev_ff == uart_map_pkg::LOC_ENABLE) begin
        if (bank_enh) begin
          feature_control_ff <= data_prev_ff & ~uart_map_pkg::FEATURE_CONTROL_RSVD_MASK;
        end else if (div_acc) begin
          dlm_ff <= data_prev_ff;
        end else begin
          ier_ff <= data_prev_ff;
        end
      end else if (addr_prev_ff == uart_map_pkg::LOC_STATUS) begin
        if (bank_enh) begin
          efr_ff <= data_prev_ff;
        end else if (div_acc && enh_on) begin
          dld_ff <= data_prev_ff[3:0] & uart_map_pkg::DLD_MASK[3:0];
        end else begin
          fcr_ff <= data_prev_ff;
        end
      end
    end
  end

  // Locations 3 to 7; writes to status locations fall through unused
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      lcr_ff     <= uart_map_pkg::RESET_BYTE;
      mcr_ff     <= uart_map_pkg::RESET_BYTE;
      scratch_ff <= uart_map_pkg::RESET_BYTE;
      enhanced_mode_select_ff    <= uart_map_pkg::RESET_BYTE;
      for (int i = 0; i < 4; i++) begin
        flow_char_ff[i] <= uart_map_pkg::RESET_BYTE;
      end
    end else if (wr_fire) begin
      if (addr_prev_ff == uart_map_pkg::LOC_LINE_CTRL) begin
        lcr_ff <= data_prev_ff;
      end else if (bank_enh && addr_prev_ff >= uart_map_pkg::LOC_FLOW_BASE) begin
        flow_char_ff[addr_prev_ff[1:0]] <= data_prev_ff;
      end else if (addr_prev_ff == uart_map_pkg::LOC_MODEM_CTRL) begin
        mcr_ff <= data_prev_ff & ~uart_map_pkg::MCR_RSVD_MASK;
      end else if (addr_prev_ff == uart_map_pkg::LOC_SCRATCH) begin
        if (feature_control_ff[uart_map_pkg::SWAP_BIT]) begin
          enhanced_mode_select_ff <= data_prev_ff & ~uart_map_pkg::EMS_RSVD_MASK;
        end else begin
          scratch_ff <= data_prev_ff;
        end
      end
    end
  end

  // Write strobes toward the FIFOs and transmitter
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_load_stb_out      <= 1'b0;
      trigger_load_stb_out <= 1'b0;
      rx_fifo_reset_out    <= 1'b0;
      tx_fifo_reset_out    <= 1'b0;
    end else begin
      tx_load_stb_out      <= wr_fire && !bank_enh && !div_acc && (addr_prev_ff == uart_map_pkg::LOC_DATA);
      trigger_load_stb_out <= wr_fire && bank_enh && (addr_prev_ff == uart_map_pkg::LOC_DATA);
      rx_fifo_reset_out    <= wr_fire && !bank_enh && !(div_acc && enh_on) &&
                              (addr_prev_ff == uart_map_pkg::LOC_STATUS) &&
                              data_prev_ff[uart_map_pkg::RX_FIFO_RESET_BIT];
      tx_fifo_reset_out    <= wr_fire && !bank_enh && !(div_acc && enh_on) &&
                              (addr_prev_ff == uart_map_pkg::LOC_STATUS) &&
                              data_prev_ff[uart_map_pkg::TX_FIFO_RESET_BIT];
    end
  end

  // ----------------------------------------
  // Registered configuration outputs
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_holding_out              <= uart_map_pkg::RESET_BYTE;
      fifo_trigger_level_out      <= uart_map_pkg::RESET_BYTE;
      divisor_low_out             <= uart_map_pkg::RESET_BYTE;
      divisor_high_out            <= uart_map_pkg::RESET_BYTE;
      divisor_fraction_out        <= 4'h0;
      interrupt_enable_out        <= uart_map_pkg::RESET_BYTE;
      fifo_enable_out             <= 1'b0;
      dma_mode_out                <= 1'b0;
      tx_trigger_out              <= 2'h0;
      rx_trigger_out              <= 2'h0;
      line_control_out            <= uart_map_pkg::RESET_BYTE;
      modem_control_out           <= uart_map_pkg::RESET_BYTE;
      dtr_out                     <= 1'b0;
      rts_out                     <= 1'b0;
      interrupt_output_enable_out <= 1'b0;
      loopback_out                <= 1'b0;
      feature_control_out         <= uart_map_pkg::RESET_BYTE;
      enhanced_function_out       <= uart_map_pkg::RESET_BYTE;
      enhanced_mode_select_out    <= uart_map_pkg::RESET_BYTE;
    end else begin
      tx_holding_out              <= thr_ff;
      fifo_trigger_level_out      <= trg_ff;
      divisor_low_out             <= dll_ff;
      divisor_high_out            <= dlm_ff;
      divisor_fraction_out        <= enh_on ? dld_ff : 4'h0;
      interrupt_enable_out        <= ier_eff;
      fifo_enable_out             <= fcr_ff[uart_map_pkg::FIFO_ENABLE_BIT];
      dma_mode_out                <= fcr_ff[uart_map_pkg::DMA_MODE_BIT];
      tx_trigger_out              <= enh_on ? fcr_ff[uart_map_pkg::TX_TRIG_LSB +: 2] : 2'h0;
      rx_trigger_out              <= fcr_ff[uart_map_pkg::RX_TRIG_LSB +: 2];
      line_control_out            <= lcr_ff;
      modem_control_out           <= mcr_eff;
      dtr_out                     <= mcr_ff[uart_map_pkg::DTR_BIT];
      rts_out                     <= mcr_ff[uart_map_pkg::RTS_BIT];
      interrupt_output_enable_out <= mcr_ff[uart_map_pkg::INT_OUT_EN_BIT];
      loopback_out                <= mcr_ff[uart_map_pkg::LOOPBACK_BIT];
      feature_control_out         <= feature_control_ff;
      enhanced_function_out       <= efr_ff;
      enhanced_mode_select_out    <= enhanced_mode_select_ff;
    end
  end

  // Flow characters leave straight from their storage flops
  assign flow_resume_char_one_out = flow_char_ff[0];
  assign flow_resume_char_two_out = flow_char_ff[1];
  assign flow_stop_char_one_out   = flow_char_ff[2];
  assign flow_stop_char_two_out   = flow_char_ff[3];

endmodule

// >>> testbench/uart_map_monitor.sv
// Checker of host bus timing and enhanced bit gating at the decoder ports
module uart_map_monitor (
  // Clock, reset and host pins
  input wire logic       clk_in, rst_in, cs_n_in, rd_n_in, data_oe_out,
  // Strobes
  input wire logic       rx_read_stb_out, tx_load_stb_out, trigger_load_stb_out, rx_fifo_reset_out,
  // Data and configuration
  input wire logic [7:0] data_in, data_out, rx_holding_in, tx_holding_out, interrupt_enable_out,
  input wire logic [7:0] modem_control_out, enhanced_function_out,
  input wire logic [3:0] divisor_fraction_out,
  input wire logic [1:0] tx_trigger_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Read data only follows a selected read strobe and is released after it
  property p_oe_read; $rose(data_oe_out) |-> !$past(rd_n_in, 2) && !$past(cs_n_in, 2); endproperty
  a_oe_read: assert property (p_oe_read) else $error("bus driven without read");
  property p_oe_drop; $rose(rd_n_in) |-> ##[1:4] !data_oe_out; endproperty
  a_oe_drop: assert property (p_oe_drop) else $error("bus not released");
  property p_rx_read; rx_read_stb_out |-> (data_oe_out && data_out == $past(rx_holding_in)) ##1 !rx_read_stb_out;
  endproperty
  a_rx_read: assert property (p_rx_read) else $error("receive byte read wrong");
  property p_tx_load; tx_load_stb_out |=> tx_holding_out == data_in && !tx_load_stb_out; endproperty
  a_tx_load: assert property (p_tx_load) else $error("transmit byte load wrong");
  property p_dld; !enhanced_function_out[4] |-> divisor_fraction_out == 4'h0; endproperty
  a_dld: assert property (p_dld) else $error("fraction active while locked");
  property p_ier; !enhanced_function_out[4] |-> interrupt_enable_out[7:4] == 4'h0; endproperty
  a_ier: assert property (p_ier) else $error("enable upper bits active while locked");
  property p_mcr; modem_control_out[2] == 1'b0 && (enhanced_function_out[4] || modem_control_out[7:5] == 3'h0);
  endproperty
  a_mcr: assert property (p_mcr) else $error("modem control gating wrong");
  property p_fifo; rx_fifo_reset_out |=> !rx_fifo_reset_out && (enhanced_function_out[4] || tx_trigger_out == 2'h0);
  endproperty
  a_fifo: assert property (p_fifo) else $error("FIFO control fields wrong");
  c_rx: cover property (rx_read_stb_out);
  c_tx: cover property (tx_load_stb_out);
  c_trig: cover property (trigger_load_stb_out);
endmodule
bind uart_register_map_decoder uart_map_monitor u_mon (.clk_in, .rst_in, .cs_n_in, .rd_n_in, .data_oe_out,
  .rx_read_stb_out, .tx_load_stb_out, .trigger_load_stb_out, .rx_fifo_reset_out, .data_in, .data_out,
  .rx_holding_in, .tx_holding_out, .interrupt_enable_out, .modem_control_out, .enhanced_function_out,
  .divisor_fraction_out, .tx_trigger_out);

// >>> testbench/uart_host_model.sv
// Host processor model driving the parallel register bus
module uart_host_model (
  input  wire logic       clk_in, data_oe_in,
  input  wire logic [7:0] rdata_in,
  output logic            cs_n_out, rd_n_out, wr_n_out,
  output logic      [2:0] addr_out,
  output logic      [7:0] data_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {cs_n_out, rd_n_out, wr_n_out} = 3'h7;
    addr_out = 3'h0;
    data_out = 8'h00;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // Address and data settle before the strobe and hold well after it
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr_out = a; data_out = d; cs_n_out = 1'b0;
    step(4); wr_n_out = 1'b0;
    step(4); wr_n_out = 1'b1;
    step(6); cs_n_out = 1'b1; data_out = ~d;
    step(4);
  endtask
  // Read data is taken at the edge where the device drives the bus
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    addr_out = a; cs_n_out = 1'b0;
    step(4); rd_n_out = 1'b0;
    for (int i = 0; i < 8 && data_oe_in !== 1'b1; i++) step(1);
    d = rdata_in;
    step(2); rd_n_out = 1'b1;
    step(6); cs_n_out = 1'b1;
    step(4);
  endtask
endmodule

// >>> testbench/uart_register_map_decoder_tb_top.sv
// Testbench running register map access sequences against the decoder
module uart_register_map_decoder_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in = 1'b0, rst_in = 1'b1, cs_n, rd_n, wr_n, oe;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, rx_hold = 8'hA5, line_status = 8'h61, modem_status = 8'hB4, rxf = 8'h11, txf = 8'h22;
  logic [5:0] src = 6'h3F;
  logic [7:0] txh, fifo_trigger_level, dlo, lco, mco, fco, ems, fr1, fs2;
  logic [3:0] dfr;
  logic [1:0] ttg, rtg;
  logic       fen, dma, dtr, rts, ioe, lpb;
  wire logic [7:0] stb;
  int         stb_cnt [8];
  int mismatches = 0, total_checks = 0, cycles = 0;
  always #2.5 clk_in = ~clk_in;
  // Strobes counted at the falling edge, midway through their single cycle
  always @(negedge clk_in) for (int i = 0; i < 8; i++) stb_cnt[i] += stb[i];
  uart_host_model host (.clk_in(clk_in), .data_oe_in(oe), .rdata_in(rdata), .cs_n_out(cs_n), .rd_n_out(rd_n),
    .wr_n_out(wr_n), .addr_out(addr), .data_out(wdata));
  uart_register_map_decoder dut (.clk_in(clk_in), .rst_in(rst_in), .cs_n_in(cs_n), .rd_n_in(rd_n), .wr_n_in(wr_n),
    .addr_in(addr), .data_in(wdata), .data_out(rdata), .data_oe_out(oe), .rx_holding_in(rx_hold),
    .int_source_in(src), .line_status_in(line_status), .modem_status_in(modem_status), .rx_fill_level_in(rxf),
    .tx_fill_level_in(txf), .rx_read_stb_out(stb[0]), .int_status_read_stb_out(stb[1]),
    .line_status_read_stb_out(stb[2]), .modem_status_read_stb_out(stb[3]), .tx_load_stb_out(stb[4]),
    .trigger_load_stb_out(stb[5]), .rx_fifo_reset_out(stb[6]), .tx_fifo_reset_out(stb[7]), .tx_holding_out(txh),
    .fifo_trigger_level_out(fifo_trigger_level), .divisor_low_out(dlo), .divisor_high_out(),
    .divisor_fraction_out(dfr), .interrupt_enable_out(), .fifo_enable_out(fen), .dma_mode_out(dma),
    .tx_trigger_out(ttg), .rx_trigger_out(rtg), .line_control_out(lco), .modem_control_out(mco), .dtr_out(dtr),
    .rts_out(rts), .interrupt_output_enable_out(ioe), .loopback_out(lpb), .feature_control_out(fco),
    .enhanced_function_out(), .enhanced_mode_select_out(ems), .flow_resume_char_one_out(fr1),
    .flow_resume_char_two_out(), .flow_stop_char_one_out(), .flow_stop_char_two_out(fs2));
  task automatic chk(input string n, input logic [7:0] s, e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rc(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk($sformatf("location %0d", a), d, e);
  endtask
  task automatic close_out;
    if (mismatches == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Cycle ceiling against a hung access
  always @(posedge clk_in) begin
    cycles++;
    if (cycles > 5000) begin
      mismatches++;
      close_out();
    end
  end
  // Access sequences across the three banks
  initial begin
    repeat (6) @(posedge clk_in);
    #1 rst_in = 1'b0;
    host.step(3);
    host.wr(3, 8'h00); host.wr(1, 8'hFF); rc(1, 8'h0F);
    rc(0, 8'hA5); rx_hold = 8'h69; rc(0, 8'h69); host.wr(0, 8'h3C);
    rc(2, 8'h0F);
    host.wr(7, 8'h5C); rc(7, 8'h5C);
    host.wr(5, 8'hFF); rc(5, 8'h61);
    rc(6, 8'hB4);
    host.wr(4, 8'hFF); rc(4, 8'h1B);
    host.wr(3, 8'h80); rc(0, 8'h5A); rc(1, 8'h3C);
    host.wr(0, 8'h12); rc(0, 8'h12); rc(2, 8'h0F);
    host.wr(3, 8'hBF); host.wr(2, 8'h10); host.wr(1, 8'h40); rc(2, 8'h10);
    host.wr(0, 8'h55); rc(0, 8'h11); rc(3, 8'hBF);
    for (int i = 4; i < 8; i++) host.wr(i[2:0], 8'(8'hC0 + i));
    for (int i = 4; i < 8; i++) rc(i[2:0], 8'(8'hC0 + i));
    host.wr(3, 8'h80); host.wr(2, 8'h37); rc(2, 8'h07);
    host.wr(3, 8'h03); rc(1, 8'hFF); rc(4, 8'hFB);
    rc(7, 8'h11); host.wr(7, 8'h0F); rc(7, 8'h11);
    host.wr(2, 8'hDF); rc(2, 8'hFF); rc(3, 8'h03);
    host.wr(3, 8'hBF); host.wr(1, 8'hC0); rc(0, 8'h22);
    host.wr(3, 8'h03); rc(7, 8'h22);
    // Configuration outputs and strobe counts after all sequences
    chk("tx holding", txh, 8'h3C);
    chk("divisor low", dlo, 8'h12);
    chk("fraction", {4'h0, dfr}, 8'h07);
    chk("fifo fields", {fen, dma, ttg, rtg, 2'h0}, 8'hDC);
    chk("line control", lco, 8'h03);
    chk("modem pins", {4'h0, lpb, ioe, rts, dtr}, 8'h0F);
    chk("enhanced mode", ems, 8'h03);
    chk("trigger level", fifo_trigger_level, 8'h55);
    chk("feature control", fco, 8'hC0);
    chk("resume char", fr1, 8'hC4);
    chk("stop char", fs2, 8'hC7);
    chk("modem control", mco, 8'hFB);
    chk("rx reads", 8'(stb_cnt[0]), 8'h02);
    chk("status reads", 8'(stb_cnt[1]), 8'h03);
    chk("line status reads", 8'(stb_cnt[2]), 8'h01);
    chk("modem status reads", 8'(stb_cnt[3]), 8'h01);
    chk("tx loads", 8'(stb_cnt[4]), 8'h01);
    chk("trigger loads", 8'(stb_cnt[5]), 8'h01);
    chk("rx fifo resets", 8'(stb_cnt[6]), 8'h01);
    chk("tx fifo resets", 8'(stb_cnt[7]), 8'h01);
    close_out();
  end
endmodule
